// ### design/brbi_receiver.v
// Bus receiver interface: device selector, flag and twelve-bit buffer register
// How it works
// - Six address bits must match device code
// - First pulse tests flag, pulls skip low
// - Address match enables the buffer bus gate
// - Second pulse clears flag and loads buffer
// - Flag set only on rising set input
// - Set, enabled flag pulls interrupt line low
// - Flag state shown on status output
// - Flag cleared by second pulse or initialize
// - Unaddressed module never loads the buffer
// - All twelve bits captured at once
// - Buffer contents driven continuously out
`timescale 1ns/100ps
`include "brbi_consts.vh"
module brbi_receiver #(
  parameter [`BRBI_ADDR_W-1:0] DEVICE_CODE = `BRBI_DEV_CODE
) (
  // Clock and reset
  input  wire                    mclk_in,
  input  wire                    rst_n_in,
  // Processor I/O bus inputs
  input  wire [`BRBI_ADDR_W-1:0] memory_buffer_bits_in,
  input  wire                    first_io_pulse_in,
  input  wire                    second_io_pulse_in,
  input  wire [`BRBI_DATA_W-1:0] accumulator_bus_lines_in,
  input  wire                    initialize_input_in,
  // Processor I/O bus open-collector outputs
  output reg                     skip_out,
  output reg                     skip_oe_out,
  output reg                     interrupt_out,
  output reg                     interrupt_oe_out,
  // External device side
  input  wire                    flag_set_input_in,
  input  wire                    interrupt_enable_in,
  output reg                     flag_status_output_out,
  output reg                     option_select_out,
  output reg  [`BRBI_DATA_W-1:0] buffer_out
);
  reg  [`BRBI_ADDR_W-1:0] addr_s1;
  reg  [`BRBI_ADDR_W-1:0] addr_s2;
  reg  [`BRBI_DATA_W-1:0] data_s1;
  reg  [`BRBI_DATA_W-1:0] data_s2;
  reg                     ien_s1;
  reg                     ien_s2;
  reg                     flag;
  wire                    first_rise;
  wire                    second_rise;
  wire                    init_level;
  wire                    init_rise;
  wire                    set_rise;
  wire                    selected;
  wire                    flag_test_strobe;
  wire                    buffer_load_strobe;
  wire [`BRBI_DATA_W-1:0] gated_data;
  reg                     next_flag;

  // Address lines pass two flip-flops before the compare
  always @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      // A code that cannot match, so nothing looks addressed after reset
      addr_s1 <= ~DEVICE_CODE;
      addr_s2 <= ~DEVICE_CODE;
    end
    else
    begin
      addr_s1 <= memory_buffer_bits_in;
      addr_s2 <= addr_s1;
    end
  end

  // Data lines use the same depth as the pulses, so a word held before the pulse is whole
  always @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      data_s1 <= `BRBI_DATA_RST;
      data_s2 <= `BRBI_DATA_RST;
    end
    else
    begin
      data_s1 <= accumulator_bus_lines_in;
      data_s2 <= data_s1;
    end
  end

  // Interrupt enable level
  always @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      ien_s1 <= 1'b0;
      ien_s2 <= 1'b0;
    end
    else
    begin
      ien_s1 <= interrupt_enable_in;
      ien_s2 <= ien_s1;
    end
  end

  brbi_sync_edge u_first (
    .mclk_in   (mclk_in),
    .rst_n_in  (rst_n_in),
    .async_in  (first_io_pulse_in),
    .level_out (),
    .rise_out  (first_rise)
  );

  brbi_sync_edge u_second (
    .mclk_in   (mclk_in),
    .rst_n_in  (rst_n_in),
    .async_in  (second_io_pulse_in),
    .level_out (),
    .rise_out  (second_rise)
  );

  brbi_sync_edge u_init (
    .mclk_in   (mclk_in),
    .rst_n_in  (rst_n_in),
    .async_in  (initialize_input_in),
    .level_out (init_level),
    .rise_out  (init_rise)
  );

  brbi_sync_edge u_set (
    .mclk_in   (mclk_in),
    .rst_n_in  (rst_n_in),
    .async_in  (flag_set_input_in),
    .level_out (),
    .rise_out  (set_rise)
  );

  // Address compare against the wired device code
  function code_match;
    input [`BRBI_ADDR_W-1:0] code;
    input [`BRBI_ADDR_W-1:0] own;
    begin
      code_match = (code == own);
    end
  endfunction

  // A pulse edge counts only while the module is addressed
  function qualify;
    input pulse;
    input sel;
    begin
      qualify = pulse & sel;
    end
  endfunction

  assign selected           = code_match(addr_s2, DEVICE_CODE);
  assign flag_test_strobe   = qualify(first_rise, selected);
  assign buffer_load_strobe = qualify(second_rise, selected);
  // Bus gate passes data only while addressed
  assign gated_data = selected ? data_s2 : `BRBI_DATA_RST;

  // Clears win over a simultaneous set edge, as a jam clear would
  always @*
  begin
    next_flag = flag;
    if (set_rise)
      next_flag = 1'b1;
    if (buffer_load_strobe | init_rise | init_level)
      next_flag = 1'b0;
  end

  // Flag and its status copy
  always @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      flag                   <= 1'b0;
      flag_status_output_out <= 1'b0;
    end
    else
    begin
      flag                   <= next_flag;
      flag_status_output_out <= next_flag;
    end
  end

  // Option select level, registered so the pin comes from a flip-flop
  always @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      option_select_out <= 1'b0;
    end
    else
    begin
      option_select_out <= selected;
    end
  end

  // Loads only from the gated bus, so an unaddressed pulse cannot reach it
  always @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      buffer_out <= `BRBI_DATA_RST;
    end
    else
    begin
      if (buffer_load_strobe)
        buffer_out <= gated_data;
    end
  end

  // Open-collector skip: data held low, enable pulses for one cycle
  always @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      skip_out    <= 1'b0;
      skip_oe_out <= 1'b0;
    end
    else
    begin
      skip_out    <= 1'b0;
      skip_oe_out <= flag_test_strobe & flag;
    end
  end

  // Open-collector interrupt request follows the flag with no extra cycle
  always @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      interrupt_out    <= 1'b0;
      interrupt_oe_out <= 1'b0;
    end
    else
    begin
      interrupt_out    <= 1'b0;
      interrupt_oe_out <= next_flag & ien_s2;
    end
  end
endmodule // brbi_receiver

// ### design/brbi_consts.vh
// Constants for the twelve-bit bus receiver buffer interface
`ifndef BRBI_CONSTS_VH
`define BRBI_CONSTS_VH
`define BRBI_ADDR_W      6
`define BRBI_DATA_W      12
`define BRBI_DATA_RST    12'h000
`define BRBI_DEV_CODE    6'h00
`define BRBI_SYNC_RST    2'h0
`endif

// ### design/brbi_sync_edge.v
// Two-stage synchroniser with rising-edge detector
`timescale 1ns/100ps
module brbi_sync_edge (
  // Clock and reset
  input  wire mclk_in,
  input  wire rst_n_in,
  // Asynchronous level in
  input  wire async_in,
  // Synchronised level and rising-edge pulse
  output reg  level_out,
  output wire rise_out
);
  reg meta;
  reg level_q;

  always @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      meta      <= 1'b0;
      level_out <= 1'b0;
      level_q   <= 1'b0;
    end
    else
    begin
      meta      <= async_in;
      level_out <= meta;
      level_q   <= level_out;
    end
  end

  assign rise_out = level_out & ~level_q;
endmodule // brbi_sync_edge

// ### testbench/brbi_host.sv
// Processor I/O bus model driving the receiver
`timescale 1ns/100ps
module brbi_host (
  // Clock and bus lines toward the receiver
  input  wire        mclk_in,
  output reg  [5:0]  memory_buffer_bits_in = 6'h3F,
  output reg         first_io_pulse_in = 1'b0,
  output reg         second_io_pulse_in = 1'b0,
  output reg  [11:0] accumulator_bus_lines_in = 12'h000
);
  task io(input [5:0] a, input [11:0] d, input s);
  begin
    @(posedge mclk_in);
    memory_buffer_bits_in <= a;
    accumulator_bus_lines_in <= d;
    repeat (4) @(posedge mclk_in);
    if (s) second_io_pulse_in <= 1'b1;
    else first_io_pulse_in <= 1'b1;
    repeat (4) @(posedge mclk_in);
    first_io_pulse_in <= 1'b0;
    second_io_pulse_in <= 1'b0;
    repeat (3) @(posedge mclk_in);
    // Released lines show the inverse of their last value
    memory_buffer_bits_in <= ~a;
    accumulator_bus_lines_in <= ~d;
  end
  endtask
endmodule // brbi_host

// ### testbench/brbi_props.sv
// Checker for the receiver ports
`timescale 1ns/100ps
module brbi_props (
  input wire        mclk_in, rst_n_in, first_io_pulse_in, second_io_pulse_in, initialize_input_in,
  input wire        flag_set_input_in, skip_out, skip_oe_out, interrupt_out, interrupt_oe_out,
  input wire        flag_status_output_out, option_select_out,
  input wire [11:0] buffer_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  wire f = flag_status_output_out, k = skip_oe_out, o = option_select_out;
  skip_test_a: assert property ($rose(first_io_pulse_in) && f && o |-> ##[3:4] k) else $error("no skip");
  skip_once_a: assert property (k |=> !k) else $error("long skip");
  skip_sel_a: assert property (k |-> $past(o) && $past(f)) else $error("bad skip");
  irq_flag_a: assert property (interrupt_oe_out |-> f) else $error("bad irq");
  drive_low_a: assert property (!skip_out && !interrupt_out) else $error("drives high");
  flag_set_a: assert property ($rose(flag_set_input_in) |-> ##[1:3] f) else $error("no set");
  flag_clr_a: assert property ($fell(f) |-> $past(second_io_pulse_in, 2) || $past(initialize_input_in, 2))
    else $error("bad clear");
  buf_load_a: assert property ($changed(buffer_out) |-> $past(o) && $past(second_io_pulse_in, 2) && !f)
    else $error("bad load");
  cover property (k);
  cover property ($changed(buffer_out));
  cover property (interrupt_oe_out);
endmodule // brbi_props
bind brbi_receiver brbi_props brbi_props_inst (.*);

// ### testbench/tb_top.sv
// Self-checking bench for the bus receiver
`timescale 1ns/100ps
`include "brbi_consts.vh"
`define CHK(n, e, g) begin #1 compares++; if ((g) !== (e)) begin err_count++; \
  $display("unexpected %s exp %h got %h", n, e, g); end end
module tb_top;
  reg         mclk_in = 0, rst_n_in = 0, initialize_input_in = 0, flag_set_input_in = 0;
  reg         interrupt_enable_in = 0;
  wire [5:0]  memory_buffer_bits_in;
  wire [11:0] accumulator_bus_lines_in, buffer_out;
  wire        first_io_pulse_in, second_io_pulse_in, skip_out, skip_oe_out, interrupt_out, interrupt_oe_out;
  wire        flag_status_output_out, option_select_out;
  int         err_count = 0, compares = 0, cyc = 0, skips = 0, skips0 = 0;
  localparam [5:0] DEV = `BRBI_DEV_CODE;
  brbi_receiver brbi_receiver_inst (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
    .memory_buffer_bits_in(memory_buffer_bits_in), .first_io_pulse_in(first_io_pulse_in),
    .second_io_pulse_in(second_io_pulse_in), .accumulator_bus_lines_in(accumulator_bus_lines_in),
    .initialize_input_in(initialize_input_in), .skip_out(skip_out), .skip_oe_out(skip_oe_out),
    .interrupt_out(interrupt_out), .interrupt_oe_out(interrupt_oe_out), .flag_set_input_in(flag_set_input_in),
    .interrupt_enable_in(interrupt_enable_in), .flag_status_output_out(flag_status_output_out),
    .option_select_out(option_select_out), .buffer_out(buffer_out));
  brbi_host brbi_host_inst (.mclk_in(mclk_in), .memory_buffer_bits_in(memory_buffer_bits_in),
    .first_io_pulse_in(first_io_pulse_in), .second_io_pulse_in(second_io_pulse_in),
    .accumulator_bus_lines_in(accumulator_bus_lines_in));
  initial forever #12.5 mclk_in = ~mclk_in;
  // Counts one-cycle skip pulses from the receiver
  always @(posedge mclk_in) if (skip_oe_out === 1'b1) skips <= skips + 1;
  task go(input int n); repeat (n) @(posedge mclk_in); endtask
  task results;
  begin
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  end
  endtask
  task t_flag;
  begin
    flag_set_input_in <= 1'b1;
    go(5);
    `CHK("flag", 1'b1, flag_status_output_out)
    `CHK("irq off", 1'b0, interrupt_oe_out)
    go(1);
    interrupt_enable_in <= 1'b1;
    go(5);
    `CHK("irq on", 1'b1, interrupt_oe_out)
    skips0 = skips;
    brbi_host_inst.io(DEV, 12'h000, 1'b0);
    `CHK("skip", 1'b1, skips != skips0)
    `CHK("skip width", 32'h1, skips - skips0)
  end
  endtask
  task t_load;
  begin
    brbi_host_inst.io(6'h15, 12'hA5C, 1'b1);
    `CHK("buf other", 12'h000, buffer_out)
    `CHK("flag kept", 1'b1, flag_status_output_out)
    `CHK("opt other", 1'b0, option_select_out)
    brbi_host_inst.io(DEV, 12'hA5C, 1'b1);
    `CHK("buf", 12'hA5C, buffer_out)
    `CHK("flag clr", 1'b0, flag_status_output_out)
    `CHK("opt sel", 1'b1, option_select_out)
    `CHK("irq clr", 1'b0, interrupt_oe_out)
    skips0 = skips;
    brbi_host_inst.io(DEV, 12'h000, 1'b0);
    `CHK("no skip", 32'h0, skips - skips0)
    go(5);
    `CHK("held set", 1'b0, flag_status_output_out)
    go(1);
    flag_set_input_in <= 1'b0;
    go(3);
    flag_set_input_in <= 1'b1;
    go(5);
    `CHK("flag again", 1'b1, flag_status_output_out)
    go(1);
    initialize_input_in <= 1'b1;
    go(4);
    initialize_input_in <= 1'b0;
    go(4);
    `CHK("flag init", 1'b0, flag_status_output_out)
    brbi_host_inst.io(DEV, 12'h5A3, 1'b1);
    `CHK("buf all", 12'h5A3, buffer_out)
  end
  endtask
  initial
  begin
    go(5);
    rst_n_in <= 1'b1;
    go(4);
    t_flag;
    t_load;
    results;
  end
  always @(posedge mclk_in)
  begin
    cyc++;
    if (cyc == 1000)
    begin
      err_count++;
      results;
    end
  end
endmodule // tb_top
